// [src/scgc_defs.vh]
`ifndef SCGC_DEFS_VH
`define SCGC_DEFS_VH
// register indices on the plain port (4-bit address)
`define SCGC_ADDR_PROTECT   4'h0
`define SCGC_ADDR_CTRL0     4'h1
`define SCGC_ADDR_CTRL1     4'h2
`define SCGC_ADDR_OSD       4'h3
`define SCGC_ADDR_FAST      4'h4
`define SCGC_ADDR_STATUS    4'h5
// protect register field
`define SCGC_PROT_UNLOCK    0
// control 0 fields
`define SCGC_C0_MSTOP       5
`define SCGC_C0_DIV8        6
// control 1 fields
`define SCGC_C1_STOPREQ     0
`define SCGC_C1_DRIVE       3
`define SCGC_C1_PINSEL      4
`define SCGC_C1_SLOWOFF     5
`define SCGC_C1_DIVLO       6
`define SCGC_C1_DIVHI       7
// stop-detect control fields
`define SCGC_OSD_EN_LO      0
`define SCGC_OSD_EN_HI      1
`define SCGC_OSD_SYSSEL     2
`define SCGC_OSD_STOPPED    3
// fast oscillator control fields
`define SCGC_FA_ON          0
`define SCGC_FA_SRC         1
// reset values
`define SCGC_RST_CTRL0      8'h60
`define SCGC_RST_CTRL1      8'h08
`define SCGC_RST_OSD        8'h04
`define SCGC_RST_FAST       8'h00
// detect-enable encodings
`define SCGC_OSD_ON         2'h3
`define SCGC_OSD_OFF        2'h0
// missing-edge timeout for stop detection, in ns, and cycles at 25 MHz
`define SCGC_CLK_NS         40
`define SCGC_STOP_NS        2000
`define SCGC_STOP_CYC       (`SCGC_STOP_NS / `SCGC_CLK_NS)
`endif

// [src/scgc_clock_ctrl.v]
`timescale 1ns/10ps
`include "scgc_defs.vh"
module scgc_clock_ctrl (
    // clock, reset, enable
    input  wire       core_clk,
    input  wire       rst_n,
    input  wire       clkEn,
    // register port
    input  wire [3:0] regAddr,
    input  wire [7:0] regWrData,
    input  wire       regWr,
    input  wire       regRd,
    output reg  [7:0] regRdData,
    // device context
    input  wire       wdtProtectMode,
    input  wire       oscInPin,
    // oscillator and pin controls
    output reg        mainOscEn,
    output reg        fastOscEn,
    output reg        slowOscEn,
    output reg        feedbackEn,
    output reg        highDrive,
    output reg        portPinsFree,
    output reg        oscOutPinOut,
    output reg        oscOutPinOe,
    // clock selection
    output reg        sysClkMain,
    output reg        onchipFast,
    output reg  [4:0] cpuDivRatio
);
    // control state
    reg       unlock_r;
    reg       mainStop_r;
    reg       div8_r;
    reg       stopReq_r;
    reg       drive_r;
    reg       pinSel_r;
    reg       slowOff_r;
    reg [1:0] divFld_r;
    reg [1:0] osdEn_r;
    reg       sysSel_r;
    reg       stopped_r;
    reg       fastOn_r;
    reg       srcSel_r;
    // pin synchroniser and the level it last settled on
    reg       sync1_r;
    reg       sync2_r;
    reg       sync3_r;
    reg       pinLevel_r;
    // missing-edge counter
    reg [7:0] lossCnt_r;
    // combinational decode and next values
    reg       wrC0;
    reg       wrC1;
    reg       wrOsd;
    reg       wrFast;
    reg       stopped_nxt;

    // reset images; each field is picked out of them bit by bit
    localparam [7:0]  RST_C0   = `SCGC_RST_CTRL0;
    localparam [7:0]  RST_C1   = `SCGC_RST_CTRL1;
    localparam [7:0]  RST_OSD  = `SCGC_RST_OSD;
    localparam [7:0]  RST_FAST = `SCGC_RST_FAST;
    // loss limit, cut to the counter width on purpose
    localparam [31:0] STOP_CYC = `SCGC_STOP_CYC;
    localparam [7:0]  STOP_LIM = STOP_CYC[7:0];

    // divider code to ratio
    // divider encoding
    function [4:0] scgc_ratio;
        input       div8;
        input [1:0] fld;
        begin
            if (div8)
                scgc_ratio = 5'h08;
            else if (fld == 2'h0)
                scgc_ratio = 5'h01;
            else if (fld == 2'h1)
                scgc_ratio = 5'h02;
            else if (fld == 2'h2)
                scgc_ratio = 5'h04;
            else
                scgc_ratio = 5'h10;
        end
    endfunction

    wire wrOk   = regWr & unlock_r;
    wire detOn  = (osdEn_r == `SCGC_OSD_ON);
    // a write that turns detection on keeps the flag from clearing in the same cycle
    wire detArm = wrOsd & ({regWrData[`SCGC_OSD_EN_HI], regWrData[`SCGC_OSD_EN_LO]}
                           == `SCGC_OSD_ON);
    wire mainRunning = ~mainStop_r & pinSel_r;
    // the pin counts as moved once stages two and three agree on a new level,
    // so a metastable first stage never makes a false edge
    wire pinSettled = (sync2_r == sync3_r);
    wire pinEdge = pinSettled & (sync3_r != pinLevel_r);
    wire lossNow = detOn & mainRunning & (lossCnt_r == STOP_LIM);
    // the output pin is high only while driven; low when released keeps
    // its idle value equal to its reset value
    wire pinDrive = pinSel_r & (stopReq_r | mainStop_r);
    // stop entry counts as from main mode only when main clock selected
    wire stopEntry = wrC1 & ~wdtProtectMode & regWrData[`SCGC_C1_STOPREQ]
                     & ~stopReq_r & ~sysSel_r;

    // write decode; a locked port decodes to nothing
    always @* begin
        wrC0   = 1'b0;
        wrC1   = 1'b0;
        wrOsd  = 1'b0;
        wrFast = 1'b0;
        if (wrOk && regAddr == `SCGC_ADDR_CTRL0)
            wrC0 = 1'b1;
        else if (wrOk && regAddr == `SCGC_ADDR_CTRL1)
            wrC1 = 1'b1;
        else if (wrOk && regAddr == `SCGC_ADDR_OSD)
            wrOsd = 1'b1;
        else if (wrOk && regAddr == `SCGC_ADDR_FAST)
            wrFast = 1'b1;
    end

    // stopped flag next value; a loss beats a returning edge in one cycle
    // flag only when enabled
    always @* begin
        stopped_nxt = stopped_r;
        if (!detOn && !detArm)
            stopped_nxt = 1'b0;
        else if (lossNow)
            stopped_nxt = 1'b1;
        else if (pinEdge)
            stopped_nxt = 1'b0;
    end

    // oscillator input synchroniser and missing-edge counter
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r   <= 1'b0;
            sync2_r   <= 1'b0;
            sync3_r   <= 1'b0;
            pinLevel_r <= 1'b0;
            lossCnt_r <= 8'h00;
        end else if (clkEn) begin
            sync1_r <= oscInPin;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            // settled level follows only when the late stages agree
            if (pinSettled)
                pinLevel_r <= sync3_r;
            // counter parks at the limit so the flag stays until edges return
            if (pinEdge || !mainRunning || !detOn)
                lossCnt_r <= 8'h00;
            else if (lossCnt_r != STOP_LIM)
                lossCnt_r <= lossCnt_r + 8'h01;
        end
    end

    // register writes and hardware side effects
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            unlock_r   <= 1'b0;
            mainStop_r <= RST_C0[`SCGC_C0_MSTOP];
            div8_r     <= RST_C0[`SCGC_C0_DIV8];
            stopReq_r  <= RST_C1[`SCGC_C1_STOPREQ];
            drive_r    <= RST_C1[`SCGC_C1_DRIVE];
            pinSel_r   <= RST_C1[`SCGC_C1_PINSEL];
            slowOff_r  <= RST_C1[`SCGC_C1_SLOWOFF];
            divFld_r   <= {RST_C1[`SCGC_C1_DIVHI], RST_C1[`SCGC_C1_DIVLO]};
            osdEn_r    <= {RST_OSD[`SCGC_OSD_EN_HI], RST_OSD[`SCGC_OSD_EN_LO]};
            sysSel_r   <= RST_OSD[`SCGC_OSD_SYSSEL];
            stopped_r  <= RST_OSD[`SCGC_OSD_STOPPED];
            fastOn_r   <= RST_FAST[`SCGC_FA_ON];
            srcSel_r   <= RST_FAST[`SCGC_FA_SRC];
        end else if (clkEn) begin
            if (regWr && regAddr == `SCGC_ADDR_PROTECT)
                unlock_r <= regWrData[`SCGC_PROT_UNLOCK];
            if (wrC0) begin
                mainStop_r <= regWrData[`SCGC_C0_MSTOP];
                div8_r     <= regWrData[`SCGC_C0_DIV8];
            end
            if (wrC1) begin
                drive_r  <= regWrData[`SCGC_C1_DRIVE];
                pinSel_r <= regWrData[`SCGC_C1_PINSEL];
                divFld_r <= {regWrData[`SCGC_C1_DIVHI], regWrData[`SCGC_C1_DIVLO]};
                if (!wdtProtectMode) begin
                    stopReq_r <= regWrData[`SCGC_C1_STOPREQ];
                    if (!sysSel_r || !regWrData[`SCGC_C1_SLOWOFF])
                        slowOff_r <= regWrData[`SCGC_C1_SLOWOFF];
                end
            end
            if (stopEntry) begin
                div8_r  <= 1'b1;
                drive_r <= 1'b1;
            end
            if (wrOsd) begin
                osdEn_r <= {regWrData[`SCGC_OSD_EN_HI], regWrData[`SCGC_OSD_EN_LO]};
                if (!(stopped_r && !regWrData[`SCGC_OSD_SYSSEL])) begin
                    sysSel_r <= regWrData[`SCGC_OSD_SYSSEL];
                    slowOff_r <= ~regWrData[`SCGC_OSD_SYSSEL];
                end
            end
            if (lossNow) begin
                sysSel_r  <= 1'b1;
                slowOff_r <= 1'b0;
            end
            // flag takes the value prepared by its decode
            stopped_r <= stopped_nxt;
            if (wrFast) begin
                fastOn_r <= regWrData[`SCGC_FA_ON];
                srcSel_r <= regWrData[`SCGC_FA_SRC];
            end
        end
    end

    // derived outputs, all registered
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mainOscEn    <= 1'b0;
            fastOscEn    <= 1'b0;
            slowOscEn    <= 1'b1;
            feedbackEn   <= 1'b1;
            highDrive    <= 1'b1;
            portPinsFree <= 1'b1;
            oscOutPinOut <= 1'b0;
            oscOutPinOe  <= 1'b0;
            sysClkMain   <= 1'b0;
            onchipFast   <= 1'b0;
            cpuDivRatio  <= 5'h08;
        end else if (clkEn) begin
            mainOscEn   <= mainRunning & ~stopReq_r;
            fastOscEn   <= fastOn_r & ~stopReq_r;
            slowOscEn   <= ~slowOff_r & ~stopReq_r;
            feedbackEn  <= ~stopReq_r;
            highDrive   <= drive_r;
            portPinsFree <= mainStop_r;
            oscOutPinOut <= pinDrive;
            oscOutPinOe  <= pinDrive;
            sysClkMain  <= ~sysSel_r;
            onchipFast  <= fastOn_r & srcSel_r;
            cpuDivRatio <= scgc_ratio(div8_r, divFld_r);
        end
    end

    // read port, data one cycle after strobe
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            regRdData <= 8'h00;
        else if (clkEn) begin
            if (!regRd)
                regRdData <= 8'h00;
            else if (regAddr == `SCGC_ADDR_PROTECT)
                regRdData <= {7'h00, unlock_r};
            else if (regAddr == `SCGC_ADDR_CTRL0)
                regRdData <= {1'b0, div8_r, mainStop_r, 5'h00};
            else if (regAddr == `SCGC_ADDR_CTRL1)
                regRdData <= {divFld_r, slowOff_r, pinSel_r, drive_r, 2'h0, stopReq_r};
            else if (regAddr == `SCGC_ADDR_OSD)
                regRdData <= {4'h0, stopped_r, sysSel_r, osdEn_r};
            else if (regAddr == `SCGC_ADDR_FAST)
                regRdData <= {6'h00, srcSel_r, fastOn_r};
            else if (regAddr == `SCGC_ADDR_STATUS)
                regRdData <= {5'h00, mainOscEn, slowOscEn, fastOscEn};
            else
                regRdData <= 8'h00;
        end
    end
endmodule

// [dv/scgc_ctrl_properties.sv]
`timescale 1ns/10ps
// port checks on the clock control block
module scgc_ctrl_properties (
    // clock and reset
    input wire       core_clk,
    input wire       rst_n,
    // register port
    input wire       clkEn,
    input wire [3:0] regAddr,
    input wire       regRd,
    input wire [7:0] regRdData,
    // oscillator and pins
    input wire       mainOscEn,
    input wire       fastOscEn,
    input wire       onchipFast,
    input wire       feedbackEn,
    input wire       portPinsFree,
    input wire       oscOutPinOut,
    input wire       oscOutPinOe,
    input wire [4:0] cpuDivRatio
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // idle or unmapped reads must leave zero behind
    sequence s_quiet;
        clkEn && (!regRd || regAddr > 4'h5);
    endsequence
    sequence s_boot;
        !mainOscEn && cpuDivRatio == 5'h08 && !oscOutPinOe;
    endsequence
    chk_read_quiet: assert property (s_quiet |=> regRdData == 8'h00)
        else $error("read data not zero");
    chk_boot_state: assert property ($rose(rst_n) |-> s_boot)
        else $error("bad state after reset");
    chk_ratio_legal: assert property (
        cpuDivRatio inside {5'h01, 5'h02, 5'h04, 5'h08, 5'h10})
        else $error("illegal ratio");
    // a low enable must freeze the selection, or glitches reach the core
    chk_enable_freeze: assert property (!clkEn |=> $stable(cpuDivRatio) && $stable(mainOscEn))
        else $error("moved while frozen");
    chk_fast_source: assert property (onchipFast |-> fastOscEn)
        else $error("fast source while off");
    chk_pins_free: assert property (mainOscEn |-> !portPinsFree)
        else $error("pins freed while running");
    chk_feedback_cut: assert property (!feedbackEn |-> oscOutPinOe)
        else $error("feedback cut, pin idle");
    chk_pin_high: assert property (oscOutPinOe |-> oscOutPinOut)
        else $error("driven pin not high");
endmodule

bind scgc_clock_ctrl scgc_ctrl_properties u_scgc_ctrl_properties (.core_clk, .rst_n,
    .clkEn, .regAddr, .regRd, .regRdData, .mainOscEn, .fastOscEn, .onchipFast,
    .feedbackEn, .portPinsFree, .oscOutPinOut, .oscOutPinOe, .cpuDivRatio);

// [dv/scgc_osc_model.sv]
`timescale 1ns/10ps
// resonator on the oscillator input pin
module scgc_osc_model (
    // from block and bench
    input  wire mainOscEn,
    input  wire failNow,
    // to the block
    output reg  oscInPin
);
    initial oscInPin = 1'b0;
    // swings only while enabled
    // a failure parks the pin, as a dead crystal would
    always #100 if (mainOscEn && !failNow) oscInPin = ~oscInPin;
endmodule

// [dv/system_clock_generation_control_test.sv]
`timescale 1ns/10ps
module system_clock_generation_control_test;
    // stimulus
    reg        core_clk = 1'b0;
    reg        rst_n = 1'b0;
    reg        clkEn = 1'b1;
    reg  [3:0] regAddr = 4'h0;
    reg  [7:0] regWrData = 8'h00;
    reg        regWr = 1'b0;
    reg        regRd = 1'b0;
    reg        wdtProtectMode = 1'b0;
    reg        failNow = 1'b0;
    // observed
    wire [7:0] regRdData;
    wire [4:0] cpuDivRatio;
    wire       oscInPin, mainOscEn, fastOscEn, slowOscEn, feedbackEn, highDrive;
    wire       portPinsFree, oscOutPinOut, oscOutPinOe, sysClkMain, onchipFast;
    wire [7:0] pins = {mainOscEn, fastOscEn, sysClkMain, onchipFast, portPinsFree,
                       oscOutPinOe, oscOutPinOut, feedbackEn};
    integer    n_fail = 0;
    integer    checks_done = 0;
    integer    i;
    // 25 MHz clock
    always #20 core_clk = ~core_clk;
    scgc_clock_ctrl u_scgc_clock_ctrl (.core_clk, .rst_n, .clkEn, .regAddr, .regWrData,
        .regWr, .regRd, .regRdData, .wdtProtectMode, .oscInPin, .mainOscEn, .fastOscEn,
        .slowOscEn, .feedbackEn, .highDrive, .portPinsFree, .oscOutPinOut, .oscOutPinOe,
        .sysClkMain, .onchipFast, .cpuDivRatio);
    scgc_osc_model u_scgc_osc_model (.mainOscEn, .failNow, .oscInPin);
    task check(input [7:0] seen, input [7:0] exp);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("unexpected at %0t: %h, wanted %h", $time, seen, exp);
            end
        end
    endtask
    // one-cycle strobes; ends on an edge so the next call waits one
    task wr(input [3:0] a, input [7:0] d);
        begin
            @(posedge core_clk);
            {regWr, regAddr, regWrData} <= {1'b1, a, d};
            @(posedge core_clk);
            regWr <= 1'b0;
        end
    endtask
    task rd(input [3:0] a, input [7:0] exp);
        begin
            @(posedge core_clk);
            {regRd, regAddr} <= {1'b1, a};
            @(posedge core_clk);
            regRd <= 1'b0;
            #1 check(regRdData, exp);
        end
    endtask
    // derived outputs lag the register by one edge
    task settle;
        begin
            repeat (2) @(posedge core_clk);
            #1;
        end
    endtask
    task t_reset;
        begin
            check(pins, 8'h09);
            check({3'h0, cpuDivRatio}, 8'h08);
            rd(4'h1, 8'h60);
            rd(4'h3, 8'h04);
            rd(4'hf, 8'h00);
            wr(4'h1, 8'h28);
            rd(4'h1, 8'h60);
            wr(4'h0, 8'h01);
            clkEn <= 1'b0;
            wr(4'h1, 8'h28);
            clkEn <= 1'b1;
            rd(4'h1, 8'h60);
            $display("reset and lock done");
        end
    endtask
    task t_div;
        begin
            wr(4'h1, 8'h28);
            for (i = 0; i < 4; i = i + 1) begin
                wr(4'h2, {i[1:0], 6'h00});
                settle;
                check({3'h0, cpuDivRatio}, 8'h01 << (i == 3 ? 4 : i));
            end
            wr(4'h1, 8'h68);
            wr(4'h4, 8'h01);
            wr(4'h4, 8'h03);
            settle;
            check({3'h0, cpuDivRatio}, 8'h08);
            check(pins, 8'h59);
            wr(4'h4, 8'h01);
            $display("divider done");
        end
    endtask
    task t_loss;
        begin
            wr(4'h2, 8'h10);
            wr(4'h1, 8'h08);
            settle;
            check(pins, 8'hc1);
            rd(4'h5, 8'h07);
            repeat (10) @(posedge core_clk);
            wr(4'h3, 8'h03);
            rd(4'h2, 8'h30);
            failNow <= 1'b1;
            for (i = 0; i < 200 && sysClkMain === 1'b1; i = i + 1)
                @(posedge core_clk);
            #1 check({6'h0, sysClkMain, slowOscEn}, 8'h01);
            rd(4'h3, 8'h0f);
            rd(4'h2, 8'h10);
            wr(4'h3, 8'h0b);
            rd(4'h3, 8'h0f);
            failNow <= 1'b0;
            repeat (20) @(posedge core_clk);
            wr(4'h3, 8'h00);
            failNow <= 1'b1;
            repeat (80) @(posedge core_clk);
            rd(4'h3, 8'h00);
            check({7'h0, sysClkMain}, 8'h01);
            failNow <= 1'b0;
            $display("stop detection done");
        end
    endtask
    task t_stop;
        begin
            wr(4'h2, 8'h31);
            settle;
            check({5'h0, feedbackEn, oscOutPinOe, oscOutPinOut}, 8'h03);
            check({3'h0, cpuDivRatio}, 8'h08);
            check({7'h0, highDrive}, 8'h01);
            rd(4'h2, 8'h39);
            wr(4'h2, 8'h38);
            wdtProtectMode <= 1'b1;
            wr(4'h2, 8'h19);
            wdtProtectMode <= 1'b0;
            rd(4'h2, 8'h38);
            wr(4'h3, 8'h04);
            wr(4'h1, 8'h68);
            settle;
            check({6'h0, portPinsFree, oscOutPinOe}, 8'h03);
            $display("stop mode done");
        end
    endtask
    task stop_test;
        begin
            $display("checks %0d, mismatches %0d", checks_done, n_fail);
            if (n_fail == 0 && checks_done > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    // main sequence
    initial begin
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        settle;
        t_reset;
        t_div;
        t_loss;
        t_stop;
        stop_test;
    end
    // watchdog: the run needs under a thousand cycles
    initial begin
        repeat (4000) @(posedge core_clk);
        n_fail = n_fail + 1;
        stop_test;
    end
endmodule
